/* File: rtl/can_mode_pkg.sv */
package can_mode_pkg;

    // ==========================================================
    // register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_GCTL = 8'h00;
    localparam logic [7:0] OFS_GLOBAL_STATUS_REG = 8'h04;
    localparam logic [7:0] OFS_GCFG = 8'h08;
    localparam logic [7:0] OFS_ISTS = 8'h0c;
    localparam logic [7:0] OFS_IMSK = 8'h10;
    localparam logic [7:0] OFS_RADR = 8'h14;
    localparam logic [7:0] OFS_RDAT = 8'h18;
    // channel n sits at {CH_BASE + n, field}
    localparam logic [3:0] CH_BASE = 4'h2;
    localparam logic [3:0] CH_CTL = 4'h0;
    localparam logic [3:0] CH_STS = 4'h4;
    localparam logic [3:0] CH_ERR = 4'h8;
    localparam logic [3:0] CH_CFG = 4'hc;

    // ==========================================================
    // fields and values
    localparam int CTL_W = 3;
    localparam int SLEEP_BIT = 2;
    localparam int ST_RESET = 0;
    localparam int ST_HALT = 1;
    localparam int ST_SLEEP = 2;
    localparam int ST_RAMINIT = 3;
    localparam int ST_COMRDY = 3;
    localparam int ST_BLF = 0;
    localparam logic [1:0] GSEL_OPER = 2'h0;
    localparam logic [1:0] GSEL_RESET = 2'h1;
    localparam logic [1:0] GSEL_TEST = 2'h2;
    localparam logic [1:0] CSEL_COMM = 2'h0;
    localparam logic [1:0] CSEL_RESET = 2'h1;
    localparam logic [1:0] CSEL_HALT = 2'h2;
    localparam logic [2:0] CTL_RST_VAL = 3'h1;

    // ==========================================================
    // timing
    localparam int CLK_NS = 10;
    localparam int BIT_NS = 1000;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    localparam int IDLE_BITS = 11;
    localparam int LOCK_BITS = 11;

    // ==========================================================
    // modes
    typedef enum logic [2:0] {G_INIT, G_RESET, G_TEST, G_OPER, G_STOP} gmode_e;
    typedef enum logic [1:0] {C_RESET, C_HALT, C_COMM, C_STOP} cmode_e;

endpackage : can_mode_pkg

/* File: rtl/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    // clock and control
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // pins in, filtered out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    // ==========================================================
    // three stages, change taken when stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            out_q <= '1;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
        end
    end

    assign dout = out_q;
endmodule : bit_sync
`default_nettype wire

/* File: rtl/msg_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module msg_ram #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 32,
    localparam int AW = $clog2(DEPTH)
) (
    // clock and control
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // access port
    input wire logic wrEn,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wrData,
    output logic [WIDTH-1:0] rdData,
    // init state
    output logic initBusy
);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("msg_ram DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] ptr_q;
    logic busy_q;
    logic [WIDTH-1:0] rdData_q;

    // ==========================================================
    // clearing walk after reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ptr_q <= '0;
            busy_q <= 1'b1;
        end else if (ce && busy_q) begin
            ptr_q <= ptr_q + AW'(1);
            if (ptr_q == AW'(DEPTH - 1)) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // array, registered read
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (busy_q) begin
                mem[ptr_q] <= '0;
            end else if (wrEn) begin
                mem[addr] <= wrData;
            end
            rdData_q <= mem[addr];
        end
    end

    assign rdData = rdData_q;
    assign initBusy = busy_q;
endmodule : msg_ram
`default_nettype wire

/* File: rtl/can_mode_config_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - ram init flag held at one during RAM clearing, cleared when done
// - global status shows the new global mode once it took effect
// - channel status shows the new channel mode once it took effect
// - in communication, 11 recessive bits set comm ready, channel goes active
// - channel reset is entered at once, regardless of traffic
// - global config survives global reset mode
// - channel config survives channel reset mode
// - global mode changes force dependent channel modes
// - global stop forces channels to stop and freezes bus observers, blocks writes except the global control, keeps registers
// - no channel is active unless global mode is operating
// - halted channel stops all bus activity
// - halt from communication refused while bus lock flag is set; reset still possible
module can_mode_config_sequencer
    import can_mode_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int RAM_DEPTH = 64,
    parameter int BIT_CYCLES = BIT_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // bus side
    input wire logic [NUM_CH-1:0] canRx,
    output logic [NUM_CH-1:0] chanActive,
    // interrupt
    output logic irq
);
    if (NUM_CH < 1 || NUM_CH > 8 || BIT_CYCLES < 1) begin : g_chk
        $error("NUM_CH must be 1..8 and BIT_CYCLES at least 1");
    end

    localparam int IDLE_CYC = IDLE_BITS * BIT_CYCLES;
    localparam int LOCK_CYC = LOCK_BITS * BIT_CYCLES;
    localparam int CNT_W = $clog2((IDLE_CYC > LOCK_CYC ? IDLE_CYC : LOCK_CYC) + 1);
    localparam logic [CNT_W-1:0] IDLE_MAX = CNT_W'(IDLE_CYC);
    localparam logic [CNT_W-1:0] LOCK_MAX = CNT_W'(LOCK_CYC);
    localparam int RAM_AW = $clog2(RAM_DEPTH);
    localparam int EV_W = NUM_CH + 2;
    localparam int EV_RAM = 0;
    localparam int EV_GLB = 1;

    // ==========================================================
    // decode helpers
    function automatic logic chHit(input logic [ADDR_W-1:0] a, input int ch,
                                   input logic [3:0] fld);
        chHit = a == {CH_BASE + 4'(ch), fld};
    endfunction : chHit

    function automatic gmode_e gWant(input logic [CTL_W-1:0] ctl, input gmode_e cur);
        gWant = cur;
        if (ctl[SLEEP_BIT]) begin
            if (cur == G_RESET) begin
                gWant = G_STOP;
            end
        end else if (cur == G_STOP) begin
            gWant = G_RESET;
        end else begin
            case (ctl[1:0])
                GSEL_OPER: gWant = G_OPER;
                GSEL_RESET: gWant = G_RESET;
                GSEL_TEST: gWant = G_TEST;
                default: gWant = cur;
            endcase
        end
    endfunction : gWant

    function automatic cmode_e cWant(input logic [CTL_W-1:0] ctl, input cmode_e cur,
                                     input gmode_e g);
        cWant = cur;
        if (ctl[SLEEP_BIT]) begin
            if (cur == C_RESET) begin
                cWant = C_STOP;
            end
        end else if (cur == C_STOP) begin
            cWant = C_RESET;
        end else begin
            case (ctl[1:0])
                CSEL_COMM: cWant = (g == G_OPER) ? C_COMM : cur;
                CSEL_RESET: cWant = C_RESET;
                CSEL_HALT: cWant = (g == G_OPER || g == G_TEST) ? C_HALT : cur;
                default: cWant = cur;
            endcase
        end
    endfunction : cWant

    // ==========================================================
    // state
    logic [CTL_W-1:0] gCtl_q;
    logic [DATA_W-1:0] gCfg_q;
    gmode_e gState_q;
    gmode_e gTarget_q;
    logic gPend_q;
    logic gDone_q;
    logic [EV_W-1:0] irqSts_q;
    logic [EV_W-1:0] irqMsk_q;
    logic irq_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdNext;
    logic [RAM_AW-1:0] ramAdr_q;
    logic [DATA_W-1:0] ramRd;
    logic ramBusy;
    logic ramBusy_q;
    logic [CTL_W-1:0] cCtl_q [NUM_CH];
    logic [DATA_W-1:0] cCfg_q [NUM_CH];
    cmode_e cState_q [NUM_CH];
    cmode_e cTarget_q [NUM_CH];
    logic [CNT_W-1:0] recCnt_q [NUM_CH];
    logic [CNT_W-1:0] domCnt_q [NUM_CH];
    logic [NUM_CH-1:0] cPend_q;
    logic [NUM_CH-1:0] cDone_q;
    logic [NUM_CH-1:0] commRdy_q;
    logic [NUM_CH-1:0] blf_q;
    logic [NUM_CH-1:0] active_q;
    logic [NUM_CH-1:0] rxBit;
    logic [NUM_CH-1:0] busIdle;
    logic wrOk;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !ce);

    // writes have no effect in global stop, except the global control
    assign wrOk = regWr && gState_q != G_STOP;

    // ==========================================================
    // pin sync and message RAM
    bit_sync #(.WIDTH(NUM_CH)) u_rxSync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .din(canRx),
        .dout(rxBit)
    );

    msg_ram #(.DEPTH(RAM_DEPTH), .WIDTH(DATA_W)) u_ram (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .wrEn(wrOk && regAddr == OFS_RDAT),
        .addr(ramAdr_q),
        .wrData(regWdata),
        .rdData(ramRd),
        .initBusy(ramBusy)
    );

    // ==========================================================
    // global registers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gCtl_q <= CTL_RST_VAL;
            gCfg_q <= '0;
            irqMsk_q <= '0;
            ramAdr_q <= '0;
        end else if (ce) begin
            if (regWr && regAddr == OFS_GCTL && !gPend_q) begin
                gCtl_q <= regWdata[CTL_W-1:0];
            end
            if (wrOk && regAddr == OFS_GCFG) begin
                gCfg_q <= regWdata;
            end
            if (wrOk && regAddr == OFS_IMSK) begin
                irqMsk_q <= regWdata[EV_W-1:0];
            end
            if (wrOk && regAddr == OFS_RADR) begin
                ramAdr_q <= regWdata[RAM_AW-1:0];
            end
        end
    end

    // ==========================================================
    // global mode sequencer
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gState_q <= G_INIT;
            gTarget_q <= G_INIT;
            gPend_q <= 1'b0;
            gDone_q <= 1'b0;
        end else if (ce) begin
            gDone_q <= gPend_q;
            if (gState_q == G_INIT) begin
                if (!ramBusy) begin
                    gState_q <= G_RESET;
                end
            end else if (gPend_q) begin
                gState_q <= gTarget_q;
                gPend_q <= 1'b0;
            end else if (gWant(gCtl_q, gState_q) != gState_q) begin
                gTarget_q <= gWant(gCtl_q, gState_q);
                gPend_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        cmode_e want;
        cmode_e cNext;
        logic haltOk;

        assign busIdle[i] = recCnt_q[i] == IDLE_MAX;

        always_comb begin
            want = cWant(cCtl_q[i], cState_q[i], gState_q);
            haltOk = !(want == C_HALT && cState_q[i] == C_COMM && (!busIdle[i] || blf_q[i]));
            cNext = cState_q[i];
            if ((gState_q == G_INIT || gState_q == G_RESET) &&
                (cState_q[i] == C_COMM || cState_q[i] == C_HALT)) begin
                cNext = C_RESET;
            end else if (gState_q == G_STOP) begin
                cNext = C_STOP;
            end else if (gState_q == G_TEST && cState_q[i] == C_COMM) begin
                cNext = C_HALT;
            end else if (want == C_RESET && cState_q[i] != C_RESET) begin
                cNext = C_RESET;
            end else if (cPend_q[i]) begin
                cNext = cTarget_q[i];
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                cState_q[i] <= C_RESET;
                cTarget_q[i] <= C_RESET;
                cPend_q[i] <= 1'b0;
                cDone_q[i] <= 1'b0;
            end else if (ce) begin
                cState_q[i] <= cNext;
                cDone_q[i] <= cNext != cState_q[i];
                cPend_q[i] <= 1'b0;
                if (!cPend_q[i] && cNext == cState_q[i] && want != cState_q[i] && haltOk) begin
                    cTarget_q[i] <= want;
                    cPend_q[i] <= 1'b1;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                cCtl_q[i] <= CTL_RST_VAL;
                cCfg_q[i] <= '0;
            end else if (ce && wrOk) begin
                if (chHit(regAddr, i, CH_CTL) &&
                    (!cPend_q[i] || regWdata[1:0] == CSEL_RESET)) begin
                    cCtl_q[i] <= regWdata[CTL_W-1:0];
                end
                if (chHit(regAddr, i, CH_CFG)) begin
                    cCfg_q[i] <= regWdata;
                end
            end
        end

        // bus observers, frozen in global stop
        always_ff @(posedge clk_sys) begin
            if (!resetn) begin
                recCnt_q[i] <= '0;
                domCnt_q[i] <= '0;
                blf_q[i] <= 1'b0;
                commRdy_q[i] <= 1'b0;
                active_q[i] <= 1'b0;
            end else if (ce && gState_q != G_STOP) begin
                if (!rxBit[i] || cState_q[i] != C_COMM) begin
                    recCnt_q[i] <= '0;
                end else if (!busIdle[i]) begin
                    recCnt_q[i] <= recCnt_q[i] + CNT_W'(1);
                end
                if (rxBit[i]) begin
                    domCnt_q[i] <= '0;
                end else if (domCnt_q[i] != LOCK_MAX) begin
                    domCnt_q[i] <= domCnt_q[i] + CNT_W'(1);
                end
                blf_q[i] <= domCnt_q[i] == LOCK_MAX;
                if (cState_q[i] != C_COMM) begin
                    commRdy_q[i] <= 1'b0;
                end else if (busIdle[i]) begin
                    commRdy_q[i] <= 1'b1;
                end
                active_q[i] <= commRdy_q[i] && cState_q[i] == C_COMM &&
                               gState_q == G_OPER;
            end
        end

        sequence idleSeen;
            cState_q[i] == C_COMM && busIdle[i];
        endsequence

        chan_done_a: assert property ($changed(cState_q[i]) |-> cDone_q[i])
            else $error("channel mode change not flagged");
        comm_ready_a: assert property ($rose(commRdy_q[i]) |-> $past(recCnt_q[i]) == IDLE_MAX)
            else $error("comm ready without eleven recessive bits");
        ready_follow_a: assert property (idleSeen ##1 cState_q[i] == C_COMM |-> commRdy_q[i])
            else $error("comm ready not set after idle");
        reset_now_a: assert property (wrOk && chHit(regAddr, i, CH_CTL) &&
            regWdata[1:0] == CSEL_RESET && !regWdata[SLEEP_BIT] ##1 1'b1 |=> cState_q[i] == C_RESET)
            else $error("channel reset not entered at once");
        chan_retain_a: assert property ($rose(cState_q[i] == C_RESET) |-> $stable(cCfg_q[i]))
            else $error("channel config lost on reset entry");
        global_force_a: assert property (gState_q == G_RESET [*2] |-> cState_q[i] != C_COMM)
            else $error("channel communicating under global reset");
        oper_only_a: assert property (active_q[i] |-> $past(gState_q) == G_OPER)
            else $error("channel active outside global operating");
        halt_quiet_a: assert property (cState_q[i] == C_HALT |=> !active_q[i])
            else $error("halted channel still active");
        lock_refuse_a: assert property (blf_q[i] && cState_q[i] == C_COMM &&
            gState_q == G_OPER && !cPend_q[i] |=> cState_q[i] != C_HALT)
            else $error("halt entered with bus locked");
    end

    // ==========================================================
    // events and interrupt
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ramBusy_q <= 1'b1;
            irqSts_q <= '0;
            irq_q <= 1'b0;
        end else if (ce) begin
            ramBusy_q <= ramBusy;
            irqSts_q <= (irqSts_q & ~((wrOk && regAddr == OFS_ISTS) ?
                         regWdata[EV_W-1:0] : '0)) |
                        {cDone_q, gDone_q, ramBusy_q && !ramBusy};
            irq_q <= |(irqSts_q & irqMsk_q);
        end
    end

    // ==========================================================
    // read path
    always_comb begin
        rdNext = '0;
        case (regAddr)
            OFS_GCTL: rdNext[CTL_W-1:0] = gCtl_q;
            OFS_GLOBAL_STATUS_REG: begin
                rdNext[ST_RESET] = gState_q == G_INIT || gState_q == G_RESET;
                rdNext[ST_HALT] = gState_q == G_TEST;
                rdNext[ST_SLEEP] = gState_q == G_STOP;
                rdNext[ST_RAMINIT] = ramBusy;
            end
            OFS_GCFG: rdNext = gCfg_q;
            OFS_ISTS: rdNext[EV_W-1:0] = irqSts_q;
            OFS_IMSK: rdNext[EV_W-1:0] = irqMsk_q;
            OFS_RADR: rdNext[RAM_AW-1:0] = ramAdr_q;
            OFS_RDAT: rdNext = ramRd;
            default: rdNext = '0;
        endcase
        for (int k = 0; k < NUM_CH; k++) begin
            if (chHit(regAddr, k, CH_CTL)) begin
                rdNext[CTL_W-1:0] = cCtl_q[k];
            end
            if (chHit(regAddr, k, CH_STS)) begin
                rdNext[ST_RESET] = cState_q[k] == C_RESET;
                rdNext[ST_HALT] = cState_q[k] == C_HALT;
                rdNext[ST_SLEEP] = cState_q[k] == C_STOP;
                rdNext[ST_COMRDY] = commRdy_q[k];
            end
            if (chHit(regAddr, k, CH_ERR)) begin
                rdNext[ST_BLF] = blf_q[k];
            end
            if (chHit(regAddr, k, CH_CFG)) begin
                rdNext = cCfg_q[k];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= regRd ? rdNext : '0;
        end
    end

    // ==========================================================
    // global checks
    sequence ramDone;
        $fell(ramBusy);
    endsequence

    ram_init_a: assert property (ramBusy |-> gState_q == G_INIT)
        else $error("left init while RAM clearing");
    init_exit_a: assert property (ramDone |=> gState_q == G_RESET)
        else $error("no global reset after RAM clearing");
    global_done_a: assert property (gPend_q |=> gDone_q && gState_q == $past(gTarget_q))
        else $error("global mode change not completed");
    global_retain_a: assert property ($rose(gState_q == G_RESET) |-> $stable(gCfg_q))
        else $error("global config lost on reset entry");
    stop_nowrite_a: assert property (gState_q == G_STOP && regWr &&
        regAddr == OFS_GCFG |=> $stable(gCfg_q))
        else $error("write took effect in global stop");

    assign regRdata = rdata_q;
    assign chanActive = active_q;
    assign irq = irq_q;
endmodule : can_mode_config_sequencer
`default_nettype wire

/* File: bench/can_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus network: pulled recessive, a node may hold it dominant
module can_bus_model (
    // dominant hold per channel
    input wire logic [1:0] holdDom,
    // receive levels
    output logic [1:0] canRx
);
    assign canRx = ~holdDom;
endmodule : can_bus_model
`default_nettype wire

/* File: bench/tb_can_mode_config_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_can_mode_config_sequencer;
    import can_mode_pkg::*;
    logic clk_sys, resetn, ce, regWr, regRd, irq;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, rdv;
    logic [1:0] canRx, chanActive, holdDom;
    int fails, check_count, cyc;
    can_mode_config_sequencer #(.NUM_CH(2), .RAM_DEPTH(8), .BIT_CYCLES(2)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .canRx(canRx), .chanActive(chanActive), .irq(irq));
    can_bus_model bus_u (.holdDom(holdDom), .canRx(canRx));
    // ==========================================================
    // access tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask : rd
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
        end while ((rdv & m) !== v && n < 100);
        chk("poll", rdv & m, v);
    endtask : poll
    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask : irq_is
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    // ==========================================================
    // clock, timeout, tests
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        holdDom = 2'h0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(OFS_GLOBAL_STATUS_REG);
        chk("ram init", rdv & 32'h8, 32'h8);
        poll(OFS_GLOBAL_STATUS_REG, 32'hf, 32'h1);
        wr(OFS_RADR, 32'h0);
        rd(OFS_RDAT);
        chk("ram cleared", rdv, 32'h0);
        wr(OFS_RADR, 32'h3);
        wr(OFS_RDAT, 32'h5a);
        rd(OFS_RDAT);
        chk("ram data", rdv, 32'h5a);
        rd(OFS_GCTL);
        chk("gctl rst", rdv, 32'h1);
        rd(8'hfc);
        chk("unmapped", rdv, 32'h0);
        irq_is(1'b0);
        wr(OFS_GCFG, 32'ha5);
        wr(OFS_GCTL, 32'h0);
        poll(OFS_GLOBAL_STATUS_REG, 32'hf, 32'h0);
        chk("ch1 idle", {30'h0, chanActive}, 32'h0);
        $display("test global done");
        wr(8'h20, 32'h0);
        poll(8'h24, 32'h7, 32'h0);
        chk("not ready", rdv & 32'h8, 32'h0);
        poll(8'h24, 32'h8, 32'h8);
        repeat (2) @(posedge clk_sys);
        chk("active", {30'h0, chanActive}, 32'h1);
        wr(8'h2c, 32'h3c);
        wr(8'h20, 32'h1);
        poll(8'h24, 32'h7, 32'h1);
        chk("inactive", {30'h0, chanActive}, 32'h0);
        rd(8'h2c);
        chk("ch cfg", rdv, 32'h3c);
        $display("test channel done");
        wr(8'h20, 32'h0);
        poll(8'h24, 32'h8, 32'h8);
        holdDom <= 2'h1;
        poll(8'h28, 32'h1, 32'h1);
        wr(8'h20, 32'h2);
        repeat (20) @(posedge clk_sys);
        rd(8'h24);
        chk("halt refused", rdv & 32'h7, 32'h0);
        wr(8'h20, 32'h1);
        poll(8'h24, 32'h7, 32'h1);
        holdDom <= 2'h0;
        wr(8'h20, 32'h0);
        poll(8'h24, 32'h8, 32'h8);
        wr(8'h20, 32'h2);
        poll(8'h24, 32'h7, 32'h2);
        chk("halted", {30'h0, chanActive}, 32'h0);
        wr(8'h20, 32'h1);
        poll(8'h24, 32'h7, 32'h1);
        $display("test halt done");
        wr(8'h20, 32'h0);
        poll(8'h24, 32'h8, 32'h8);
        wr(OFS_GCTL, 32'h1);
        poll(OFS_GLOBAL_STATUS_REG, 32'hf, 32'h1);
        rd(8'h24);
        chk("forced", rdv & 32'h7, 32'h1);
        chk("no comm", {30'h0, chanActive}, 32'h0);
        rd(OFS_GCFG);
        chk("g cfg", rdv, 32'ha5);
        wr(OFS_GCTL, 32'h5);
        poll(OFS_GLOBAL_STATUS_REG, 32'h4, 32'h4);
        poll(8'h34, 32'h4, 32'h4);
        wr(OFS_GCFG, 32'h77);
        rd(OFS_GCFG);
        chk("stop wr", rdv, 32'ha5);
        wr(OFS_GCTL, 32'h1);
        poll(OFS_GLOBAL_STATUS_REG, 32'hf, 32'h1);
        $display("test global modes done");
        wr(OFS_IMSK, 32'h2);
        irq_is(1'b1);
        wr(OFS_ISTS, 32'h2);
        irq_is(1'b0);
        $display("test irq done");
        complete_run();
    end
endmodule : tb_can_mode_config_sequencer
`default_nettype wire
